//--- common/lram_defines.vh
// constants of the large dual-port ram block
// assumes inclusion by lram_core.v only
`ifndef LRAM_DEFINES_VH
`define LRAM_DEFINES_VH

// array geometry: 4096 rows of sixteen 9-bit lanes
`define LRAM_BITS      589824
`define LRAM_LANE_W    9
`define LRAM_BYTE_W    8
`define LRAM_LANES     16
`define LRAM_ROW_W     144
`define LRAM_ROWS      4096
`define LRAM_FIFO_CAP  17'h10000

// operating modes
`define LRAM_MODE_TDP  2'h0
`define LRAM_MODE_SDP  2'h1
`define LRAM_MODE_SP   2'h2
`define LRAM_MODE_FIFO 2'h3

// port width codes: lanes per word = 1 << code
`define LRAM_W9        3'h0
`define LRAM_W72       3'h3
`define LRAM_W144      3'h4

// register offsets
`define LRAM_OFS_CFG   8'h00
`define LRAM_OFS_STAT  8'h04

// configuration fields
`define LRAM_CFG_RST   32'h0000_0300
`define LRAM_CFG_MODE  1:0
`define LRAM_CFG_WA    4:2
`define LRAM_CFG_WB    7:5
`define LRAM_CFG_OUTA  8
`define LRAM_CFG_OUTB  9
`define LRAM_CFG_NARA  10
`define LRAM_CFG_NARB  11

// status fields
`define LRAM_ST_ERR    0
`define LRAM_ST_EMPTY  1
`define LRAM_ST_FULL   2
`define LRAM_ST_CNT    20:4

`endif

//--- core/lram_core.v
// large embedded dual-port ram: array, two port pipelines, apb config
// assumes fabric port signals and apb on REF_CLK; no pin synchronising
`timescale 1ns/10ps
`include "lram_defines.vh"

// one port pipeline: input capture, lane steering, optional out register
module lram_port
(
   // clock and clear
   input  wire         clk,
   input  wire         clr,
   // fabric request
   input  wire         cken,
   input  wire         we,
   input  wire [15:0]  be,
   input  wire [15:0]  addr,
   input  wire [143:0] din,
   // configuration
   input  wire [2:0]   wcode,
   input  wire         narrow,
   input  wire         outreg,
   input  wire         rd_ok,
   input  wire         wr_ok,
   // array side
   input  wire [143:0] row,
   output wire         wr_v,
   output wire [11:0]  word,
   output wire [143:0] wmask,
   output wire [143:0] wdata,
   // read result
   output wire         out_v,
   output wire [143:0] out_d
);

   reg          c_wr;
   reg          c_rd;
   reg  [15:0]  c_addr;
   reg  [15:0]  c_be;
   reg  [143:0] c_din;
   reg          rd_v2;
   reg  [143:0] q;

   wire [15:0]  word_full;
   wire [15:0]  ofs_full;
   wire [3:0]   ofs;
   wire [4:0]   lanes;
   wire [16:0]  one_l;
   wire [16:0]  all_l;
   wire [15:0]  le;
   wire [15:0]  le_sh;
   wire [7:0]   bit_sh;
   wire [143:0] din_l;
   wire [143:0] rsh;
   wire [143:0] rres;

   function [143:0] lanemask;
      input [15:0] m;
      integer i;
      begin
         lanemask = {`LRAM_ROW_W{1'b0}};
         for (i = 0; i < `LRAM_LANES; i = i + 1)
            lanemask[i*`LRAM_LANE_W +: `LRAM_LANE_W] = {`LRAM_LANE_W{m[i]}};
      end
   endfunction

   function [143:0] pack8;
      input [143:0] d;
      integer i;
      begin
         pack8 = {`LRAM_ROW_W{1'b0}};
         for (i = 0; i < `LRAM_LANES; i = i + 1)
            pack8[i*`LRAM_LANE_W +: `LRAM_BYTE_W] = d[i*`LRAM_BYTE_W +: `LRAM_BYTE_W];
      end
   endfunction

   function [143:0] unpack8;
      input [143:0] d;
      integer i;
      begin
         unpack8 = {`LRAM_ROW_W{1'b0}};
         for (i = 0; i < `LRAM_LANES; i = i + 1)
            unpack8[i*`LRAM_BYTE_W +: `LRAM_BYTE_W] = d[i*`LRAM_LANE_W +: `LRAM_BYTE_W];
      end
   endfunction

   // every request is registered before it reaches the array [R4] [R17]
   always @(posedge clk or posedge clr)
   begin
      if (clr)
      begin
         c_wr   <= 1'b0;
         c_rd   <= 1'b0;
         c_addr <= 16'h0000;
         c_be   <= 16'h0000;
         c_din  <= 144'h0;
         rd_v2  <= 1'b0;
         q      <= 144'h0;
      end
      else
      begin
         c_wr  <= cken & we & wr_ok;   // [R10]
         c_rd  <= cken & ~we & rd_ok;  // [R10]
         rd_v2 <= c_rd;
         if (cken)
         begin
            c_addr <= addr;
            c_be   <= be;
            c_din  <= din;
         end
         if (c_rd)
            q <= rres;
      end
   end

   // row index and lane offset from a width-scaled address [R6]
   assign word_full = c_addr >> (`LRAM_W144 - wcode);
   assign word      = word_full[11:0];
   assign ofs_full  = {12'h000, c_addr[3:0]} << wcode;
   assign ofs       = ofs_full[3:0];
   assign lanes     = 5'h01 << wcode;
   assign one_l     = 17'h00001 << lanes;
   assign all_l     = one_l - 17'h00001;
   assign bit_sh    = {4'h0, ofs} * 8'h09;

   // 9-bit words have no enables; others mask lane by lane [R11] [R12] [R13] [R15]
   assign le    = ((wcode == `LRAM_W9) ? 16'hFFFF : c_be) & all_l[15:0];
   assign le_sh = le << ofs;
   // 8-bit modes use the same lane order, ninth bit written as zero [R16]
   assign din_l = narrow ? pack8(c_din) : c_din;
   assign wr_v  = c_wr;
   assign wmask = lanemask(le_sh);
   assign wdata = din_l << bit_sh;

   assign rsh   = (row >> bit_sh) & lanemask(all_l[15:0]);
   assign rres  = narrow ? unpack8(rsh) : rsh;

   // output register may be bypassed, giving one cycle less latency [R5]
   assign out_v = outreg ? rd_v2 : c_rd;
   assign out_d = outreg ? q : rres;

endmodule

// Behaviour
// R1: array holds 589,824 bits including parity lanes
// R2: modes true dual, simple dual, single, fifo
// R3: no preload; contents undefined until written
// R4: all inputs registered; no asynchronous access
// R5: output register optional, bypass selectable
// R6: depths 64K/32K/16K/8K/4K by width
// R7: 144-bit width refused in true dual-port
// R8: simple dual: 9..72 mix; 144 only paired
// R9: true dual: any 9..72 pair allowed
// R10: one write select per port, no read enable
// R11: write lane needs select and byte enable
// R12: byte enables for 18, 36, 72 widths
// R13: enable i covers bits 9i to 9i+8
// R14: 144 mode merges both enable sets, sixteen
// R15: any enable pattern applied lane by lane
// R16: 8-bit modes mask bytes same order
// R17: input registers share one clock
// R18: fabric supplies clock, enable, select, clear
// R19: each port 72 data in, 72 out
// R20: each port's registers own enable and clear
// R21: write side and read side registered separately
// R22: unenabled lanes keep their old contents
// R23: port clear resets registers, not array
module lram_core
(
   // clock and reset
   input  wire        REF_CLK,
   input  wire        RST,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // port a
   input  wire        CLKEN_A,
   input  wire        CLR_A,
   input  wire        WE_A,
   input  wire [7:0]  BYTEEN_A,
   input  wire [15:0] ADDR_A,
   input  wire [71:0] DIN_A,
   output reg  [71:0] DOUT_A,
   // port b
   input  wire        CLKEN_B,
   input  wire        CLR_B,
   input  wire        WE_B,
   input  wire [7:0]  BYTEEN_B,
   input  wire [15:0] ADDR_B,
   input  wire [71:0] DIN_B,
   output reg  [71:0] DOUT_B
);

   // no reset and no initial contents for the array [R1] [R3]
   reg  [143:0] mem [0:`LRAM_ROWS-1];
   reg  [31:0]  cfg;
   reg  [15:0]  wptr;
   reg  [15:0]  rptr;
   reg  [16:0]  cnt;

   wire [1:0]   mode;
   wire [2:0]   wa;
   wire [2:0]   wb;
   wire         wide;
   wire         fifo;
   wire         cfg_err;
   wire         full;
   wire         empty;
   wire [4:0]   lanes;
   wire [16:0]  cnt_next_push;
   wire         push;
   wire         pop;
   wire         acc;
   wire         cfg_wr;
   wire         hit;
   wire         rst_a;
   wire         rst_b;
   wire [15:0]  a_addr;
   wire [15:0]  b_addr;
   wire         a_wr_v;
   wire         b_wr_v;
   wire [11:0]  a_word;
   wire [11:0]  b_word;
   wire [143:0] a_mask;
   wire [143:0] b_mask;
   wire [143:0] a_wdata;
   wire [143:0] b_wdata;
   wire         a_out_v;
   wire         b_out_v;
   wire [143:0] a_out_d;
   wire [143:0] b_out_d;
   wire [143:0] a_row;
   wire [143:0] b_row;
   wire [143:0] a_merged;
   wire [143:0] ab_merged;
   wire         same_row;
   wire [31:0]  stat;

   assign mode = cfg[`LRAM_CFG_MODE];
   assign wa   = cfg[`LRAM_CFG_WA];
   assign wb   = cfg[`LRAM_CFG_WB];
   assign fifo = (mode == `LRAM_MODE_FIFO);
   // 144-bit words only as a simple dual-port pair [R8] [R14]
   assign wide = (mode == `LRAM_MODE_SDP) && (wa == `LRAM_W144) && (wb == `LRAM_W144);

   // illegal organisations stop all access [R7] [R8] [R9]
   assign cfg_err = (wa > `LRAM_W144) || (wb > `LRAM_W144)
                  || ((mode == `LRAM_MODE_TDP)
                      && ((wa == `LRAM_W144) || (wb == `LRAM_W144)))
                  || ((mode == `LRAM_MODE_SDP) && !wide
                      && ((wa == `LRAM_W144) || (wb == `LRAM_W144)))
                  || ((mode == `LRAM_MODE_SP) && (wa == `LRAM_W144))
                  || (fifo && ((wa != wb) || (wa > `LRAM_W72)));

   // fifo occupancy counted in 9-bit lanes
   assign lanes         = 5'h01 << wa;
   assign cnt_next_push = cnt + {12'h000, lanes};
   assign full  = cnt_next_push > `LRAM_FIFO_CAP;
   assign empty = (cnt == 17'h00000);
   assign push  = fifo && !cfg_err && CLKEN_A && WE_A && !full;
   assign pop   = fifo && !cfg_err && CLKEN_B && !empty;

   assign a_addr = fifo ? (wptr >> wa) : ADDR_A;
   assign b_addr = fifo ? (rptr >> wb) : ADDR_B;

   // port clear acts on its own side only [R20] [R23]
   assign rst_a = RST | CLR_A;
   assign rst_b = RST | CLR_B;

   assign a_row = mem[a_word];
   assign b_row = mem[b_word];

   // port a: writes in all modes, reads in true dual and single [R2] [R21]
   lram_port u_port_a
   (
      .clk    (REF_CLK),
      .clr    (rst_a),
      .cken   (CLKEN_A),
      .we     (fifo ? push : WE_A),
      .be     (wide ? {BYTEEN_B, BYTEEN_A} : {8'h00, BYTEEN_A}),
      .addr   (a_addr),
      .din    (wide ? {DIN_B, DIN_A} : {72'h0, DIN_A}),
      .wcode  (wa),
      .narrow (cfg[`LRAM_CFG_NARA]),
      .outreg (cfg[`LRAM_CFG_OUTA]),
      .rd_ok  (!cfg_err && ((mode == `LRAM_MODE_TDP) || (mode == `LRAM_MODE_SP))),
      .wr_ok  (!cfg_err),
      .row    (a_row),
      .wr_v   (a_wr_v),
      .word   (a_word),
      .wmask  (a_mask),
      .wdata  (a_wdata),
      .out_v  (a_out_v),
      .out_d  (a_out_d)
   );

   // port b: reads except in single mode, writes only in true dual [R2] [R21]
   lram_port u_port_b
   (
      .clk    (REF_CLK),
      .clr    (rst_b),
      .cken   (fifo ? pop : CLKEN_B),
      .we     ((mode == `LRAM_MODE_TDP) ? WE_B : 1'b0),
      .be     ({8'h00, BYTEEN_B}),
      .addr   (b_addr),
      .din    ({72'h0, DIN_B}),
      .wcode  (wb),
      .narrow (cfg[`LRAM_CFG_NARB]),
      .outreg (cfg[`LRAM_CFG_OUTB]),
      .rd_ok  (!cfg_err && (mode != `LRAM_MODE_SP)),
      .wr_ok  (!cfg_err && (mode == `LRAM_MODE_TDP)),
      .row    (b_row),
      .wr_v   (b_wr_v),
      .word   (b_word),
      .wmask  (b_mask),
      .wdata  (b_wdata),
      .out_v  (b_out_v),
      .out_d  (b_out_d)
   );

   // masked merge keeps unenabled lanes; port b wins a shared lane [R22]
   assign same_row  = a_wr_v && (a_word == b_word);
   assign a_merged  = (a_row & ~a_mask) | (a_wdata & a_mask);
   assign ab_merged = ((same_row ? a_merged : b_row) & ~b_mask) | (b_wdata & b_mask);

   always @(posedge REF_CLK)
   begin
      if (a_wr_v && !(b_wr_v && same_row))
         mem[a_word] <= a_merged;   // [R11] [R22]
      if (b_wr_v)
         mem[b_word] <= ab_merged;  // [R11] [R22]
   end

   // 72 data outputs per port; 144-bit reads split over both [R19] [R14]
   always @(posedge REF_CLK or posedge rst_a)
   begin
      if (rst_a)
         DOUT_A <= 72'h0;
      else if (wide ? b_out_v : a_out_v)
         DOUT_A <= wide ? b_out_d[71:0] : a_out_d[71:0];
   end

   always @(posedge REF_CLK or posedge rst_b)
   begin
      if (rst_b)
         DOUT_B <= 72'h0;
      else if (b_out_v)
         DOUT_B <= wide ? b_out_d[143:72] : b_out_d[71:0];
   end

   // fifo pointers; a configuration write empties the fifo
   always @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         wptr <= 16'h0000;
         rptr <= 16'h0000;
         cnt  <= 17'h00000;
      end
      else if (cfg_wr)
      begin
         wptr <= 16'h0000;
         rptr <= 16'h0000;
         cnt  <= 17'h00000;
      end
      else
      begin
         if (push)
            wptr <= wptr + {11'h000, lanes};
         if (pop)
            rptr <= rptr + {11'h000, lanes};
         if (push && !pop)
            cnt <= cnt_next_push;
         else if (pop && !push)
            cnt <= cnt - {12'h000, lanes};
      end
   end

   // apb slave: pready one cycle into the access phase
   assign acc    = PSEL && PENABLE && !PREADY;
   assign hit    = (PADDR == `LRAM_OFS_CFG) || (PADDR == `LRAM_OFS_STAT);
   assign cfg_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == `LRAM_OFS_CFG)
                 && !PSLVERR;

   assign stat = {11'h000, cnt, 1'b0, full, empty, cfg_err};

   always @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         cfg     <= `LRAM_CFG_RST;
      end
      else
      begin
         PREADY <= acc;
         if (acc)
         begin
            PSLVERR <= !hit;
            if (PWRITE || !hit)
               PRDATA <= 32'h0000_0000;
            else if (PADDR == `LRAM_OFS_CFG)
               PRDATA <= cfg;
            else
               PRDATA <= stat;
         end
         if (cfg_wr)
            cfg <= PWDATA;
      end
   end

endmodule

//--- verification/lram_fab.sv
// fabric-side model of one ram port: captures and clear
// assumes clk is the block's REF_CLK; one capture at a time
`timescale 1ns/10ps
module lram_fab
(
   // clock
   input  wire        clk,
   // port request
   output reg         cken,
   output reg         clr,
   output reg         we,
   output reg  [7:0]  be,
   output reg  [15:0] addr,
   output reg  [71:0] din
);
   initial
   begin
      cken = 1'b0;
      clr = 1'b0;
      we = 1'b0;
      be = 8'hFF;
      addr = 16'h0000;
      din = 72'h0;
   end

   // one capture edge, then released lines show inverted junk
   task cap(input w, input [15:0] a, input [7:0] b, input [71:0] d);
   begin
      @(posedge clk);
      cken <= 1'b1;
      we <= w;
      be <= b;
      addr <= a;
      din <= d;
      @(posedge clk);
      cken <= 1'b0;
      we <= ~w;
      be <= ~b;
      addr <= ~a;
      din <= ~d;
   end
   endtask

   task clear(input v);
   begin
      @(posedge clk);
      clr <= v;
   end
   endtask
endmodule

//--- verification/lram_properties.sv
// assertions on the ram block's apb answers and port outputs
// assumes binding onto lram_core; one clock, async reset RST
`timescale 1ns/10ps
module lram_props
(
   // clock and reset
   input wire        REF_CLK,
   input wire        RST,
   // apb
   input wire        PSEL,
   input wire        PENABLE,
   input wire [7:0]  PADDR,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   // ports
   input wire        CLKEN_A,
   input wire        CLR_A,
   input wire [71:0] DOUT_A,
   input wire        CLKEN_B,
   input wire        CLR_B,
   input wire [71:0] DOUT_B
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("pready held too long");
   ready_late_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("pready late");
   idle_quiet_a: assert property (!PSEL |=> !PREADY)
      else $error("pready without access");
   bad_addr_a: assert property (PREADY && PADDR != 8'h00 && PADDR != 8'h04
      |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped access answered");
   good_addr_a: assert property (PREADY && PADDR == 8'h00 |-> !PSLVERR)
      else $error("config access refused");
   rdata_hold_a: assert property (!PREADY |-> $stable(PRDATA) && $stable(PSLVERR))
      else $error("apb answer moved");
   clear_a_a: assert property (CLR_A |-> DOUT_A == 72'h0)
      else $error("port a clear ignored");
   clear_b_a: assert property (CLR_B |-> DOUT_B == 72'h0)
      else $error("port b clear ignored");
   dout_hold_a: assert property (!CLKEN_A && !CLKEN_B && !$past(CLKEN_A)
      && !$past(CLKEN_B) && !$past(CLKEN_A, 2) && !$past(CLKEN_B, 2)
      |=> CLR_A || CLR_B || ($stable(DOUT_A) && $stable(DOUT_B)))
      else $error("read data moved without read");
endmodule

bind lram_core lram_props props (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .CLKEN_A(CLKEN_A), .CLR_A(CLR_A), .DOUT_A(DOUT_A),
   .CLKEN_B(CLKEN_B), .CLR_B(CLR_B), .DOUT_B(DOUT_B));

//--- verification/tb.sv
// self-checking bench of the ram block: apb config, port traffic
// assumes lram_core with lram_fab models on both ports
`timescale 1ns/10ps
module tb;
   reg          clk = 1'b0;
   reg          rst = 1'b1;
   reg          psel = 1'b0;
   reg          pen = 1'b0;
   reg          pwr = 1'b0;
   reg  [7:0]   pa = 8'h00;
   reg  [31:0]  pwd = 32'h0;
   wire [31:0]  prd;
   wire         prdy;
   wire         perr;
   wire         cea;
   wire         cla;
   wire         wea;
   wire [7:0]   bea;
   wire [15:0]  aa;
   wire [71:0]  da;
   wire [71:0]  dout_a;
   wire         ceb;
   wire         clb;
   wire         web;
   wire [7:0]   beb;
   wire [15:0]  ab;
   wire [71:0]  db;
   wire [71:0]  dout_b;
   integer      n_mismatch = 0;
   integer      check_count = 0;
   integer      k;
   reg  [71:0]  sh [0:3];
   reg  [12:0]  rows [0:6];
   reg  [12:0]  r;
   reg  [143:0] x;
   reg  [143:0] y;
   reg  [143:0] m;
   reg  [31:0]  q;
   reg          e;

   always #50 clk = ~clk;

   lram_fab fa (.clk(clk), .cken(cea), .clr(cla), .we(wea), .be(bea), .addr(aa), .din(da));
   lram_fab fb (.clk(clk), .cken(ceb), .clr(clb), .we(web), .be(beb), .addr(ab), .din(db));
   lram_core dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
      .CLKEN_A(cea), .CLR_A(cla), .WE_A(wea), .BYTEEN_A(bea), .ADDR_A(aa), .DIN_A(da),
      .DOUT_A(dout_a), .CLKEN_B(ceb), .CLR_B(clb), .WE_B(web), .BYTEEN_B(beb),
      .ADDR_B(ab), .DIN_B(db), .DOUT_B(dout_b));

   task complete_run;
   begin
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   task chk(input [143:0] got, input [143:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task apb(input w, input [7:0] a, input [31:0] d, output [31:0] rq, output re);
   begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1)
         @(posedge clk);
      rq = prd;
      re = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   end
   endtask

   task acc(input p, input w, input [15:0] a, input [7:0] b, input [71:0] d);
   begin
      if (p)
         fb.cap(w, a, b, d);
      else
         fa.cap(w, a, b, d);
   end
   endtask

   // port a reads bypassed, port b through its output register
   task rd(input p, input [15:0] a, input [71:0] v);
      reg [71:0] o;
   begin
      o = dout_b;
      acc(p, 1'b0, a, 8'hFF, 72'h0);
      repeat (2) @(negedge clk);
      if (p)
      begin
         chk(dout_b, o);
         @(negedge clk);
         chk(dout_b, v);
      end
      else
         chk(dout_a, v);
   end
   endtask

   function [71:0] lmask(input [7:0] b);
      integer i;
   begin
      lmask = 72'h0;
      for (i = 0; i < 8; i = i + 1)
         if (b[i])
            lmask[9*i +: 9] = 9'h1FF;
   end
   endfunction

   initial
   begin
      #200000;
      n_mismatch = n_mismatch + 1;
      complete_run;
   end

   initial
   begin
      // rows: writer port, byte enables, address
      rows[0] = 13'h0FF0;
      rows[1] = 13'h0001;
      rows[2] = 13'h15A1;
      rows[3] = 13'h0812;
      rows[4] = 13'h1013;
      rows[5] = 13'h0803;
      rows[6] = 13'h1FF2;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0, q, e);
      chk(q, 32'h0000_0300);
      apb(1'b1, 8'h04, 32'hFFFF_FFFF, q, e);
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk(q, 32'h0000_0002);
      apb(1'b0, 8'h08, 32'h0, q, e);
      chk({e, q}, 33'h1_0000_0000);
      apb(1'b1, 8'h00, 32'h0000_026C, q, e);
      apb(1'b0, 8'h00, 32'h0, q, e);
      chk(q, 32'h0000_026C);
      for (k = 0; k < 4; k = k + 1)
      begin
         sh[k] = {64'h13579BDF02468ACE, k[7:0]};
         acc(1'b0, 1'b1, k[15:0], 8'hFF, sh[k]);
      end
      for (k = 0; k < 7; k = k + 1)
      begin
         r = rows[k];
         y[71:0] = ~sh[r[3:0]];
         m[71:0] = lmask(r[11:4]);
         sh[r[3:0]] = (sh[r[3:0]] & ~m[71:0]) | (y[71:0] & m[71:0]);
         acc(r[12], 1'b1, {12'h000, r[3:0]}, r[11:4], y[71:0]);
         rd(~r[12], {12'h000, r[3:0]}, sh[r[3:0]]);
      end
      fork
         fa.clear(1'b1);
         fb.clear(1'b1);
      join
      @(negedge clk);
      chk({dout_b, dout_a}, 144'h0);
      fork
         fa.clear(1'b0);
         fb.clear(1'b0);
      join
      rd(1'b0, 16'h0000, sh[0]);
      // 144 wide in true dual: flagged and write dropped
      apb(1'b1, 8'h00, 32'h0000_0270, q, e);
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk(q[0], 1'b1);
      acc(1'b0, 1'b1, 16'h0000, 8'hFF, ~sh[0]);
      apb(1'b1, 8'h00, 32'h0000_026C, q, e);
      rd(1'b1, 16'h0000, sh[0]);
      // single port, 16-bit bytes on a: masked byte keeps old value
      apb(1'b1, 8'h00, 32'h0000_0606, q, e);
      acc(1'b0, 1'b1, 16'h0003, 8'hFF, 72'h1234);
      acc(1'b0, 1'b1, 16'h0003, 8'h02, 72'hABCD);
      rd(1'b0, 16'h0003, 72'hAB34);
      // simple dual: 9-bit writes on a ignore enables, 72-bit read on b
      apb(1'b1, 8'h00, 32'h0000_0261, q, e);
      acc(1'b0, 1'b1, 16'h0010, 8'h00, 72'hFFFFFFFFFFFFFFFFA5);
      acc(1'b0, 1'b1, 16'h0017, 8'h00, 72'hFFFFFFFFFFFFFFFEC3);
      sh[2][8:0] = 9'h1A5;
      sh[2][71:63] = 9'h0C3;
      rd(1'b1, 16'h0002, sh[2]);
      // fifo of 18-bit words: two pushes, two pops, one refused pop
      apb(1'b1, 8'h00, 32'h0000_0227, q, e);
      acc(1'b0, 1'b1, 16'h0000, 8'hFF, 72'h12345);
      acc(1'b0, 1'b1, 16'h0000, 8'hFF, 72'h2ABCD);
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk(q, 32'h0000_0040);
      rd(1'b1, 16'h0000, 72'h12345);
      rd(1'b1, 16'h0000, 72'h2ABCD);
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk(q, 32'h0000_0002);
      rd(1'b1, 16'h0000, 72'h2ABCD);
      // 144 wide simple dual with merged enables
      apb(1'b1, 8'h00, 32'h0000_0091, q, e);
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk(q, 32'h0000_0002);
      x = {72'h0123456789ABCDEF01, 72'hFEDCBA98765432100F};
      for (k = 0; k < 2; k = k + 1)
      begin
         m = (k == 0) ? {144{1'b1}} : {lmask(8'h80), lmask(8'h01)};
         y = (k == 0) ? x : ~x;
         fork
            fa.cap(1'b1, 16'h0005, (k == 0) ? 8'hFF : 8'h01, y[71:0]);
            fb.cap(1'b0, 16'h0005, (k == 0) ? 8'hFF : 8'h80, y[143:72]);
         join
         x = (x & ~m) | (y & m);
      end
      fb.cap(1'b0, 16'h0005, 8'hFF, 72'h0);
      repeat (2) @(negedge clk);
      chk({dout_b, dout_a}, x);
      complete_run;
   end
endmodule
